// file: hw/tcm_channel.sv
`timescale 1ns/10ps
module tcm_channel #(
	parameter int CNT_W = 16
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        i_count_tick,
	input  wire logic        i_timer_in,
	output logic             o_channel_interrupt,
	output logic             o_channel_output
);
	import tcm_pkg::*;

	logic [15:0]      mode_reg;
	logic [CNT_W-1:0] compare_reg;
	logic [15:0]      oe_reg;
	logic             out_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cap_reg;
	logic             irq_reg;
	logic             ovf_reg;
	tcm_state_e       state_reg;
	logic [SYNC_STAGES-1:0] sync_reg;
	logic             in_lvl_reg;

	// bus decode
	wire              wr_acc      = psel & penable & pwrite;
	wire              rd_sel      = psel & ~pwrite;
	wire              hit_mode    = (paddr == OFF_MODE_CTRL);
	wire              hit_cmp     = (paddr == OFF_COMPARE);
	wire              hit_oe      = (paddr == OFF_OUT_ENABLES);
	wire              hit_lvl     = (paddr == OFF_OUT_LEVEL);
	wire              hit_ctl     = (paddr == OFF_CONTROL);
	wire              hit_sts     = (paddr == OFF_STATUS);
	wire              hit_cnt     = (paddr == OFF_COUNTER);
	wire              mapped      = hit_mode | hit_cmp | hit_oe | hit_lvl | hit_ctl
	                                | hit_sts | hit_cnt;
	wire              sw_start    = wr_acc & hit_ctl & pwdata[0];
	wire              sw_stop     = wr_acc & hit_ctl & pwdata[1];
	wire              cap_rd      = psel & penable & rd_sel & hit_sts;

	// mode fields
	wire [2:0]        op_mode     = mode_reg[POS_MODE_HI:POS_MODE_LO];
	wire              start_beh   = mode_reg[POS_START_BEH];
	wire              oe_bit      = oe_reg[POS_OE_CH];
	wire              m_int       = (op_mode == MODE_INTERVAL);
	wire              m_cap       = (op_mode == MODE_CAPTURE);
	wire              m_evt       = (op_mode == MODE_EVENT);
	wire              m_one       = (op_mode == MODE_ONE_COUNT);
	wire              m_cone      = (op_mode == MODE_CAP_ONE);
	wire              counts_up   = m_cap | m_cone;
	wire              running     = (state_reg == TCM_RUN);

	// input edge from the 3-stage synchroniser
	wire              in_agree    = (sync_reg[2] == sync_reg[1]);
	wire              in_new      = in_agree ? sync_reg[1] : in_lvl_reg;
	wire              in_edge     = in_new & ~in_lvl_reg;
	wire              in_fall     = ~in_new & in_lvl_reg;

	// start and retrigger
	wire              hw_trig     = (m_one | m_cone) & in_edge;
	wire              start_req   = sw_start | hw_trig;
	wire              retrig_ok   = m_one & start_beh;
	wire              do_start    = start_req & (~running | retrig_ok);
	wire              start_fresh = do_start & ~running;
	// interrupt and toggle on start only for interval/capture with bit set
	wire              start_evt   = start_fresh & (m_int | m_cap) & start_beh;

	// count step per mode
	wire              tick        = running & (m_evt ? in_edge : i_count_tick);
	wire              at_zero     = (cnt_reg == '0);
	wire              at_max      = (cnt_reg == {CNT_W{1'b1}});
	wire              int_wrap    = tick & m_int & at_zero;
	wire              evt_wrap    = tick & m_evt & at_zero;
	wire              one_end     = tick & m_one & at_zero;
	wire              cap_evt     = running & m_cap & in_edge;
	wire              cone_end    = running & m_cone & in_fall;
	wire              period_evt  = int_wrap | evt_wrap | one_end | cap_evt | cone_end;
	wire              fire        = period_evt | start_evt;
	wire              toggle      = oe_bit & (int_wrap | one_end | start_evt);

	// counter next value
	logic [CNT_W-1:0] cnt_next;
	always_comb begin
		cnt_next = cnt_reg;
		if (do_start)
			cnt_next = counts_up ? '0 : compare_reg;
		else if (int_wrap | evt_wrap)
			cnt_next = compare_reg;
		else if (cap_evt)
			cnt_next = '0;
		else if (tick & ~at_zero & ~counts_up)
			cnt_next = cnt_reg - 1'b1;
		else if (tick & counts_up & ~at_max)
			cnt_next = cnt_reg + 1'b1;
	end

	// run state
	tcm_state_e state_next;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			TCM_IDLE: if (do_start) state_next = TCM_RUN;
			TCM_RUN:  if (sw_stop | ((one_end | cone_end) & ~do_start)) state_next = TCM_IDLE;
		endcase
	end

	// output level: software writes only while disabled
	wire              lvl_wr      = wr_acc & hit_lvl & ~oe_bit;
	wire              out_next    = lvl_wr ? pwdata[0] : (toggle ? ~out_reg : out_reg);

	// registers written by software
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_reg    <= RST_MODE_CTRL;
			compare_reg <= CNT_W'(RST_COMPARE);
			oe_reg      <= RST_OUT_ENABLES;
		end else begin
			if (wr_acc & hit_mode) mode_reg <= pwdata[15:0] & 16'h17CF;
			if (wr_acc & hit_cmp) compare_reg <= pwdata[CNT_W-1:0];
			if (wr_acc & hit_oe) oe_reg <= pwdata[15:0] & 16'h00FF;
		end
	end

	// timer state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg   <= CNT_W'(RST_COUNTER);
			state_reg <= TCM_IDLE;
			out_reg   <= 1'b0;
			irq_reg   <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			state_reg <= state_next;
			out_reg   <= out_next;
			irq_reg   <= fire;
		end
	end

	// capture and overflow flag; a new overflow beats the read clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			if (cap_evt | cone_end) cap_reg <= cnt_reg;
			if (tick & counts_up & at_max) ovf_reg <= 1'b1;
			else if (cap_rd) ovf_reg <= 1'b0;
		end
	end

	// pin synchroniser
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_reg   <= '0;
			in_lvl_reg <= 1'b0;
		end else begin
			sync_reg   <= {sync_reg[SYNC_STAGES-2:0], i_timer_in};
			in_lvl_reg <= in_new;
		end
	end

	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_mode) rd_mux = {16'h0000, mode_reg};
		if (hit_cmp) rd_mux = 32'(compare_reg);
		if (hit_oe) rd_mux = {16'h0000, oe_reg};
		if (hit_lvl) rd_mux = {31'h0, out_reg};
		if (hit_sts) rd_mux = {14'h0, ovf_reg, running, 16'(cap_reg)};
		if (hit_cnt) rd_mux = 32'(cnt_reg);
	end

	assign prdata              = rd_mux;
	assign pready              = 1'b1;
	assign pslverr             = psel & penable & ~mapped;
	assign o_channel_interrupt = irq_reg;
	assign o_channel_output    = out_reg;

	// interval interrupt spacing check
	logic [CNT_W:0] gap_cnt;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			gap_cnt <= '0;
		else if (int_wrap | do_start)
			gap_cnt <= '0;
		else if (tick)
			gap_cnt <= gap_cnt + 1'b1;
	end

	sequence s_fresh_start;
		start_fresh & (m_int | m_cap);
	endsequence

	property p_start_beh_set;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_fresh_start ##0 start_beh |=> o_channel_interrupt;
	endproperty
	a_start_beh_set: assert property (p_start_beh_set) else $error("no start irq");

	property p_start_beh_clr;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_fresh_start ##0 (!start_beh && !period_evt) |=> !o_channel_interrupt;
	endproperty
	a_start_beh_clr: assert property (p_start_beh_clr) else $error("stray start irq");

	property p_interval_period;
		@(posedge i_clk) disable iff (!i_rst_n)
		int_wrap && !$past(do_start) |-> gap_cnt == CNT_W'(compare_reg);
	endproperty
	a_interval_period: assert property (p_interval_period) else $error("bad period");

	property p_down_count;
		@(posedge i_clk) disable iff (!i_rst_n)
		tick && !counts_up && !at_zero && !do_start && !sw_stop && !$changed(compare_reg)
		|=> cnt_reg == $past(cnt_reg) - 1'b1;
	endproperty
	a_down_count: assert property (p_down_count) else $error("no down count");

	property p_up_count;
		@(posedge i_clk) disable iff (!i_rst_n)
		tick && counts_up && !at_max && !cap_evt && !do_start
		|=> cnt_reg == $past(cnt_reg) + 1'b1;
	endproperty
	a_up_count: assert property (p_up_count) else $error("no up count");

	property p_one_stop;
		@(posedge i_clk) disable iff (!i_rst_n)
		one_end && !do_start |=> !running;
	endproperty
	a_one_stop: assert property (p_one_stop) else $error("one-count kept running");

	property p_no_retrig;
		@(posedge i_clk) disable iff (!i_rst_n)
		running && start_req && (m_one || m_cone) && !start_beh && !tick && !sw_stop
		|=> cnt_reg == $past(cnt_reg);
	endproperty
	a_no_retrig: assert property (p_no_retrig) else $error("retrigger accepted");

	property p_retrig;
		@(posedge i_clk) disable iff (!i_rst_n)
		running && start_req && m_one && start_beh && !one_end
		|=> cnt_reg == $past(compare_reg) && !o_channel_interrupt;
	endproperty
	a_retrig: assert property (p_retrig) else $error("retrigger lost");

	property p_fixed_out;
		@(posedge i_clk) disable iff (!i_rst_n)
		!oe_bit && !lvl_wr |=> o_channel_output == $past(o_channel_output);
	endproperty
	a_fixed_out: assert property (p_fixed_out) else $error("output moved");

	property p_write_ignored;
		@(posedge i_clk) disable iff (!i_rst_n)
		oe_bit && wr_acc && hit_lvl && !toggle |=> o_channel_output == $past(o_channel_output);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write not ignored");

	property p_event_silent;
		@(posedge i_clk) disable iff (!i_rst_n)
		start_fresh && m_evt |=> !o_channel_interrupt;
	endproperty
	a_event_silent: assert property (p_event_silent) else $error("event start irq");

	// end of a down-count period in the modes that drive the output
	sequence s_period_end;
		int_wrap || one_end;
	endsequence

	property p_interval_reload;
		@(posedge i_clk) disable iff (!i_rst_n)
		int_wrap
		|=> cnt_reg == $past(compare_reg) && o_channel_interrupt;
	endproperty
	a_interval_reload: assert property (p_interval_reload) else $error("no reload");

	property p_capture_latch;
		@(posedge i_clk) disable iff (!i_rst_n)
		cap_evt
		|=> cap_reg == $past(cnt_reg) && cnt_reg == '0 && o_channel_interrupt;
	endproperty
	a_capture_latch: assert property (p_capture_latch) else $error("no capture");

	property p_event_reload;
		@(posedge i_clk) disable iff (!i_rst_n)
		evt_wrap
		|=> cnt_reg == $past(compare_reg) && o_channel_interrupt;
	endproperty
	a_event_reload: assert property (p_event_reload) else $error("no event wrap");

	property p_one_end_irq;
		@(posedge i_clk) disable iff (!i_rst_n)
		one_end
		|=> o_channel_interrupt;
	endproperty
	a_one_end_irq: assert property (p_one_end_irq) else $error("no one-count irq");

	property p_width_end;
		@(posedge i_clk) disable iff (!i_rst_n)
		cone_end
		|=> !running && cap_reg == $past(cnt_reg) && o_channel_interrupt;
	endproperty
	a_width_end: assert property (p_width_end) else $error("width not latched");

	property p_start_out_clr;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_fresh_start ##0 !start_beh
		|=> o_channel_output == $past(o_channel_output);
	endproperty
	a_start_out_clr: assert property (p_start_out_clr) else $error("start moved out");

	property p_start_out_set;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_fresh_start ##0 (start_beh && oe_bit)
		|=> o_channel_output != $past(o_channel_output);
	endproperty
	a_start_out_set: assert property (p_start_out_set) else $error("no start toggle");

	property p_period_toggle;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_period_end ##0 oe_bit
		|=> o_channel_output != $past(o_channel_output);
	endproperty
	a_period_toggle: assert property (p_period_toggle) else $error("no toggle");
endmodule : tcm_channel

// file: hw/tcm_pkg.sv
package tcm_pkg;
	// register byte offsets
	localparam logic [7:0]  OFF_MODE_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_COMPARE     = 8'h04;
	localparam logic [7:0]  OFF_OUT_ENABLES = 8'h08;
	localparam logic [7:0]  OFF_OUT_LEVEL   = 8'h0C;
	localparam logic [7:0]  OFF_CONTROL     = 8'h10;
	localparam logic [7:0]  OFF_STATUS      = 8'h14;
	localparam logic [7:0]  OFF_COUNTER     = 8'h18;
	// mode and output-enable register field positions
	localparam int          POS_START_BEH   = 0;
	localparam int          POS_MODE_LO     = 1;
	localparam int          POS_MODE_HI     = 3;
	localparam int          POS_OE_CH       = 1;
	// reset values
	localparam logic [15:0] RST_MODE_CTRL   = 16'h0000;
	localparam logic [15:0] RST_COMPARE     = 16'h0000;
	localparam logic [15:0] RST_OUT_ENABLES = 16'h0000;
	localparam logic [15:0] RST_COUNTER     = 16'hFFFF;
	// operation mode encodings (mode bits 3..1)
	localparam logic [2:0]  MODE_INTERVAL   = 3'h0;
	localparam logic [2:0]  MODE_CAPTURE    = 3'h2;
	localparam logic [2:0]  MODE_EVENT      = 3'h3;
	localparam logic [2:0]  MODE_ONE_COUNT  = 3'h4;
	localparam logic [2:0]  MODE_CAP_ONE    = 3'h6;
	// pin input synchroniser depth
	localparam int          SYNC_STAGES     = 3;
	typedef enum logic [1:0] {TCM_IDLE, TCM_RUN} tcm_state_e;
endpackage : tcm_pkg

// file: test/tcm_channel_tb.sv
`timescale 1ns/10ps
module tb;
	import tcm_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        i_count_tick = 1'b0;
	logic        i_timer_in = 1'b0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         o_channel_interrupt;
	wire         o_channel_output;
	int          n_fail = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          irq_cnt = 0;
	int          last_irq = 0;
	int          gap = 0;
	tcm_channel #(.CNT_W(16)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .i_count_tick(i_count_tick),
		.i_timer_in(i_timer_in), .o_channel_interrupt(o_channel_interrupt),
		.o_channel_output(o_channel_output));
	// clock and interrupt bookkeeping, timeout
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_channel_interrupt === 1'b1) begin
			irq_cnt  <= irq_cnt + 1;
			last_irq <= cyc;
			gap      <= cyc - last_irq;
		end
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end
	task automatic stop_test();
		if (n_fail == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one apb transfer: setup, access until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd
	task automatic ticks(input int n);
		repeat (n) @(posedge i_clk) i_count_tick <= 1'b1;
		@(posedge i_clk) i_count_tick <= 1'b0;
	endtask : ticks
	task automatic pin_rise();
		@(posedge i_clk) i_timer_in <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_timer_in <= 1'b0;
		repeat (6) @(posedge i_clk);
	endtask : pin_rise
	// stop, program compare and mode, start
	task automatic run(input logic [2:0] m, input logic sb, input logic [15:0] c);
		wr(OFF_CONTROL, 32'h2);
		wr(OFF_COMPARE, {16'h0, c});
		wr(OFF_MODE_CTRL, {28'h0, m, sb});
		wr(OFF_CONTROL, 32'h1);
	endtask : run
	task automatic t_reset_map();
		logic [31:0] r;
		logic        e;
		rd(OFF_MODE_CTRL, r);
		check("mode reset", r, {16'h0, RST_MODE_CTRL});
		rd(OFF_OUT_ENABLES, r);
		check("oe reset", r, {16'h0, RST_OUT_ENABLES});
		rd(OFF_COUNTER, r);
		check("counter reset", r, {16'h0, RST_COUNTER});
		apb(1'b0, 8'h40, 32'h0, r, e);
		check("unmapped data", r, 32'h0);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("ready", {31'h0, pready}, 32'h1);
	endtask : t_reset_map
	// count direction of interval, capture and capture-one modes after a few ticks
	task automatic t_direction();
		logic [31:0] r;
		run(MODE_INTERVAL, 1'b0, 16'h000A);
		ticks(3);
		rd(OFF_COUNTER, r);
		check("interval down", r, 32'h7);
		run(MODE_CAPTURE, 1'b0, 16'h000A);
		ticks(5);
		rd(OFF_COUNTER, r);
		check("capture up", r, 32'h5);
		run(MODE_CAP_ONE, 1'b0, 16'h000A);
		ticks(4);
		rd(OFF_COUNTER, r);
		check("cap one up", r, 32'h4);
	endtask : t_direction
	// interrupt and toggle at start for each start setting
	task automatic t_start(input logic [2:0] m, input logic sb);
		int   n0;
		logic o0;
		wr(OFF_OUT_ENABLES, 32'h2);
		wr(OFF_CONTROL, 32'h2);
		o0 = o_channel_output;
		n0 = irq_cnt;
		run(m, sb, 16'h0005);
		repeat (4) @(posedge i_clk);
		check("start irq", irq_cnt - n0, {31'h0, sb});
		check("start out", {31'h0, o_channel_output ^ o0}, {31'h0, sb});
	endtask : t_start
	task automatic t_period();
		run(MODE_INTERVAL, 1'b0, 16'h0003);
		ticks(20);
		repeat (2) @(posedge i_clk);
		check("period", gap, 32'h4);
	endtask : t_period
	task automatic t_event();
		int n0;
		run(MODE_EVENT, 1'b0, 16'h0002);
		n0 = irq_cnt;
		pin_rise();
		pin_rise();
		check("event early", irq_cnt - n0, 32'h0);
		pin_rise();
		check("event irq", irq_cnt - n0, 32'h1);
	endtask : t_event
	// retrigger while counting in one-count mode
	task automatic t_retrig(input logic sb);
		logic [31:0] r;
		int          n0;
		run(MODE_ONE_COUNT, sb, 16'h000A);
		ticks(3);
		n0 = irq_cnt;
		wr(OFF_CONTROL, 32'h1);
		repeat (3) @(posedge i_clk);
		rd(OFF_COUNTER, r);
		check("retrig count", r, sb ? 32'hA : 32'h7);
		check("retrig irq", irq_cnt - n0, 32'h0);
		ticks(11);
		rd(OFF_STATUS, r);
		check("one end run", {31'h0, r[16]}, 32'h0);
		check("one end irq", irq_cnt - n0, 32'h1);
	endtask : t_retrig
	// capture latch, then high-level width started and ended by the pin
	task automatic t_capture();
		logic [31:0] r;
		int          n0;
		run(MODE_CAPTURE, 1'b0, 16'h0000);
		ticks(3);
		n0 = irq_cnt;
		pin_rise();
		rd(OFF_STATUS, r);
		check("capture status", r, 32'h0001_0003);
		check("capture irq", irq_cnt - n0, 32'h1);
		wr(OFF_CONTROL, 32'h2);
		wr(OFF_MODE_CTRL, {28'h0, MODE_CAP_ONE, 1'b0});
		n0 = irq_cnt;
		@(posedge i_clk) i_timer_in <= 1'b1;
		repeat (6) @(posedge i_clk);
		ticks(5);
		@(posedge i_clk) i_timer_in <= 1'b0;
		repeat (6) @(posedge i_clk);
		rd(OFF_STATUS, r);
		check("width status", r, 32'h0000_0005);
		check("width irq", irq_cnt - n0, 32'h1);
	endtask : t_capture
	task automatic t_output();
		logic o0;
		wr(OFF_CONTROL, 32'h2);
		wr(OFF_OUT_ENABLES, 32'h0);
		wr(OFF_OUT_LEVEL, 32'h1);
		repeat (2) @(posedge i_clk);
		check("level hi", {31'h0, o_channel_output}, 32'h1);
		wr(OFF_OUT_LEVEL, 32'h0);
		repeat (2) @(posedge i_clk);
		check("level lo", {31'h0, o_channel_output}, 32'h0);
		wr(OFF_OUT_ENABLES, 32'h2);
		o0 = o_channel_output;
		wr(OFF_OUT_LEVEL, {31'h0, ~o0});
		repeat (2) @(posedge i_clk);
		check("level ignored", {31'h0, o_channel_output}, {31'h0, o0});
	endtask : t_output
	// main sequence
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset_map();
		t_direction();
		t_start(MODE_INTERVAL, 1'b0);
		t_start(MODE_INTERVAL, 1'b1);
		t_start(MODE_CAPTURE, 1'b0);
		t_start(MODE_CAPTURE, 1'b1);
		t_start(MODE_EVENT, 1'b0);
		t_period();
		t_event();
		t_retrig(1'b0);
		t_retrig(1'b1);
		t_capture();
		t_output();
		stop_test();
	end
endmodule : tb
